// ### byte_lane_dll_delay_config.v
// Register bank for one byte lane's DLL controls and per-bit delays.
// Assumes an Avalon-MM master on clk_sys and the analog DLL and delay cells outside.
`include "byte_lane_dll_map.vh"
`timescale 1ns/1ns
`default_nettype none
module byte_lane_dll_delay_config #(
    parameter ADDR_W = 12,
    parameter NBITS = 8
) (
    input wire clk_sys,
    input wire rstn,
    input wire [ADDR_W-1:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg [1:0] avs_response,
    output reg avs_waitrequest,
    input wire master_locked,
    input wire analog_test_in,
    output reg lane_dll_bypass,
    output reg lane_dll_soft_reset,
    output reg slave_loopback_sel,
    output reg analog_probe_out,
    output reg analog_probe_oe,
    output reg [3:0] slave_phase_trim,
    output reg [7:0] slave_phase_deg,
    output reg slave_start,
    output reg phase_det_enable,
    output reg [2:0] master_ff_trim,
    output reg [2:0] master_fb_trim,
    output reg [2:0] slave_ff_trim,
    output reg [2:0] slave_fb_trim,
    output reg [NBITS*2-1:0] bit_delay_true_steps,
    output reg [NBITS*2-1:0] bit_delay_comp_steps,
    output reg [3:0] mask_delay_field
);

////////////////////////////////////////////////////////////////////////////////

reg [31:0] dllc_q;
reg [31:0] dqtr_q;
reg [31:0] dqstr_q;
reg busy_q;
reg [31:0] rd_d;
reg hit_d;
reg [31:0] bmask;
wire take = (avs_read | avs_write) & ~busy_q;

always @* begin
    bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
             {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    hit_d = 1'b1;
    case (avs_address)
        `OFS_DLL_CONTROL: rd_d = dllc_q;
        `OFS_DQ_BIT_DELAYS: rd_d = dqtr_q;
        `OFS_STROBE_TIMING: rd_d = dqstr_q;
        default: begin
            rd_d = 32'h00000000;
            hit_d = 1'b0;
        end
    endcase
end

// One wait cycle per access: accepted when waitrequest is low after the request is seen.
always @(posedge clk_sys) begin
    if (!rstn) begin
        dllc_q <= `DLLC_RESET;
        dqtr_q <= `DQTR_RESET;
        dqstr_q <= `DQSTR_RESET;
        busy_q <= 1'b0;
        avs_waitrequest <= 1'b1;
        avs_readdata <= 32'h00000000;
        avs_response <= 2'b00;
    end else begin
        busy_q <= take;
        avs_waitrequest <= ~take;
        if (take) begin
            avs_readdata <= avs_read ? rd_d : 32'h00000000;
            avs_response <= hit_d ? 2'b00 : 2'b11;
            if (avs_write) begin
                case (avs_address)
                    `OFS_DLL_CONTROL: dllc_q <= (dllc_q & ~(bmask & `DLLC_WMASK)) |
                        (avs_writedata & bmask & `DLLC_WMASK);
                    `OFS_DQ_BIT_DELAYS: dqtr_q <= (dqtr_q & ~bmask) | (avs_writedata & bmask);
                    `OFS_STROBE_TIMING: dqstr_q <= (dqstr_q & ~(bmask & `DQSTR_WMASK)) |
                        (avs_writedata & bmask & `DQSTR_WMASK);
                    default: dllc_q <= dllc_q;
                endcase
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////

wire [1:0] ph_hi = dllc_q[17:16];
wire [1:0] ph_lo = dllc_q[15:14];
wire [7:0] phase_d = `PHASE_BASE_DEG + `PHASE_STEP_DEG * {6'd0, ph_hi}
                   - `PHASE_STEP_DEG * {6'd0, ph_lo};
wire [NBITS*2-1:0] true_d;
wire [NBITS*2-1:0] comp_d;

// Per-bit delay fields split into true- and complement-strobe step counts.
genvar gi;
generate
    for (gi = 0; gi < NBITS; gi = gi + 1) begin : g_bits
        assign true_d[gi*2+1:gi*2] = dqtr_q[gi*4+1:gi*4];
        assign comp_d[gi*2+1:gi*2] = dqtr_q[gi*4+3:gi*4+2];
    end
endgenerate

always @(posedge clk_sys) begin
    if (!rstn) begin
        lane_dll_bypass <= 1'b0;
        lane_dll_soft_reset <= 1'b1;
        slave_loopback_sel <= 1'b0;
        analog_probe_out <= 1'b0;
        analog_probe_oe <= 1'b0;
        slave_phase_trim <= 4'h0;
        slave_phase_deg <= `PHASE_BASE_DEG;
        slave_start <= 1'b0;
        phase_det_enable <= 1'b1;
        master_ff_trim <= 3'h0;
        master_fb_trim <= 3'h0;
        slave_ff_trim <= 3'h0;
        slave_fb_trim <= 3'h0;
        bit_delay_true_steps <= {NBITS*2{1'b1}};
        bit_delay_comp_steps <= {NBITS*2{1'b1}};
        mask_delay_field <= 4'hF;
    end else begin
        lane_dll_bypass <= dllc_q[`DLLC_BYPASS];
        lane_dll_soft_reset <= dllc_q[`DLLC_SOFT_RESET];
        slave_loopback_sel <= dllc_q[`DLLC_LOOPBACK];
        analog_probe_out <= dllc_q[`DLLC_PROBE] & analog_test_in;
        analog_probe_oe <= dllc_q[`DLLC_PROBE];
        slave_phase_trim <= dllc_q[17:14];
        slave_phase_deg <= phase_d;
        // Auto start follows lock only in mode 0X; manual modes keep the slave idle.
        slave_start <= ~dllc_q[`START_AUTO_BIT] & master_locked;
        phase_det_enable <= ~dllc_q[`START_AUTO_BIT] | dllc_q[`START_DET_BIT];
        master_ff_trim <= dllc_q[11:9];
        master_fb_trim <= dllc_q[8:6];
        slave_ff_trim <= dllc_q[5:3];
        slave_fb_trim <= dllc_q[2:0];
        bit_delay_true_steps <= true_d;
        bit_delay_comp_steps <= comp_d;
        mask_delay_field <= dqstr_q[29:26];
    end
end

endmodule
`default_nettype wire

// ### byte_lane_dll_delay_config_tb_top.sv
// Self-checking bench for the byte lane DLL register bank.
// Assumes the bank and its port checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module byte_lane_dll_delay_config_tb_top;
    logic clk_sys = 0, rstn = 0, avs_read = 0, avs_write = 0, master_locked = 0;
    logic analog_test_in = 1, avs_waitrequest, lane_dll_bypass, lane_dll_soft_reset;
    logic slave_loopback_sel, analog_probe_out, analog_probe_oe, slave_start, phase_det_enable;
    logic [11:0] avs_address = 0;
    logic [31:0] avs_writedata = 0, avs_readdata, q, d;
    logic [3:0] avs_byteenable = 4'hF, slave_phase_trim, mask_delay_field;
    logic [1:0] avs_response, rsp;
    logic [7:0] slave_phase_deg;
    logic [2:0] master_ff_trim, master_fb_trim, slave_ff_trim, slave_fb_trim;
    logic [15:0] bit_delay_true_steps, bit_delay_comp_steps, et, ec;
    int mismatches = 0, num_checks = 0, i;
    byte_lane_dll_delay_config uut (.*);
    initial forever #5 clk_sys = ~clk_sys;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    // Holds the request until the acknowledge edge, then lets outputs settle.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= v;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clk_sys); while (avs_waitrequest);
        q = avs_readdata;
        rsp = avs_response;
        avs_write <= 0;
        avs_read <= 0;
        @(posedge clk_sys);
        #1;
    endtask
    task results;
        if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #20000;
        mismatches++;
        results;
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        rstn <= 1;
        xfer(0, 12'h1CC, 0);
        chk("ctl", 32'h40000000, q);
        xfer(0, 12'h1D0, 0);
        chk("dq", 32'hFFFFFFFF, q);
        xfer(0, 12'h1D4, 0);
        chk("strobe", 32'h3DB55000, q);
        xfer(1, 12'h1CC, 32'hFFFFFFFF);
        chk("pins", 32'h1F, {lane_dll_bypass, slave_loopback_sel, analog_probe_oe,
            analog_probe_out, lane_dll_soft_reset});
        chk("trims", 32'hFFF, {master_ff_trim, master_fb_trim, slave_ff_trim, slave_fb_trim});
        xfer(0, 12'h1CC, 0);
        chk("ctl rd", 32'hC00FFFFF, q);
        master_locked <= 1;
        for (i = 0; i < 16; i++) begin
            d = (i << 14) | ((i & 3) << 12);
            xfer(1, 12'h1CC, d);
            chk("phase", 90 + 18 * (i >> 2) - 18 * (i & 3), slave_phase_deg);
            chk("ptrim", i, slave_phase_trim);
            chk("start", {!d[13], !d[13] | d[12]}, {slave_start, phase_det_enable});
        end
        chk("off", 0, {lane_dll_bypass, analog_probe_oe, analog_probe_out, lane_dll_soft_reset});
        d = 32'h1B2D4E87;
        xfer(1, 12'h1D0, d);
        for (i = 0; i < 8; i++) begin
            et[2*i +: 2] = d[4*i +: 2];
            ec[2*i +: 2] = d[4*i+2 +: 2];
        end
        chk("true", et, bit_delay_true_steps);
        chk("comp", ec, bit_delay_comp_steps);
        xfer(1, 12'h1D4, 32'hFFFFFFFF);
        chk("mask", 32'hF, mask_delay_field);
        xfer(0, 12'h1D4, 0);
        chk("strobe rd", 32'h3FFFFFFF, q);
        xfer(1, 12'h1D8, 0);
        xfer(0, 12'h1D8, 0);
        chk("unmapped", 0, q);
        chk("resp", 32'h3, rsp);
        xfer(0, 12'h1D0, 0);
        chk("dq rd", d, q);
        @(posedge clk_sys);
        avs_byteenable <= 4'h1;
        xfer(1, 12'h1D0, 32'h00000000);
        @(posedge clk_sys);
        avs_byteenable <= 4'hF;
        xfer(0, 12'h1D0, 0);
        chk("dq lane", 32'h1B2D4E00, q);
        results;
    end
endmodule
bind byte_lane_dll_delay_config byte_lane_dll_props chk_i (.*);
`default_nettype wire

// ### byte_lane_dll_map.vh
// Register offsets, field positions, reset values and timing for the byte lane DLL bank.
// Assumes a 32-bit Avalon-MM slave with byte addresses, one word per register.
// Operation
// - DLL bypass bit 31 bypasses lane DLL.
// - Bit 30 resets to one, holds DLL reset.
// - Bit 19 removes slave 90 degree shift.
// - Bit 18 drives analog probe, else tristate.
// - Phase trim gives 90+18*hi-18*lo degrees.
// - Start field 0X auto-starts slave after lock.
// - 10 no autostart, detector off; 11 on.
// - Bits 11:9 trim master feed-forward delay.
// - Bits 8:6 trim master feedback delay.
// - Bits 5:3 trim slave feed-forward delay.
// - Bits 2:0 trim slave feedback delay.
// - Eight four-bit bit delays, reset 0xF.
// - Low pair true strobe, high pair complement.
// - Each pair adds zero to three steps.
// - Strobe register bits 31:30 reserved, mask delay.
`ifndef BYTE_LANE_DLL_MAP_VH
`define BYTE_LANE_DLL_MAP_VH
`define OFS_DLL_CONTROL 12'h1CC
`define OFS_DQ_BIT_DELAYS 12'h1D0
`define OFS_STROBE_TIMING 12'h1D4
`define DLLC_BYPASS 31
`define DLLC_SOFT_RESET 30
`define DLLC_LOOPBACK 19
`define DLLC_PROBE 18
`define DLLC_WMASK 32'hC00FFFFF
`define DLLC_RESET 32'h40000000
`define DQTR_RESET 32'hFFFFFFFF
`define DQSTR_WMASK 32'h3FFFFFFF
`define DQSTR_RESET 32'h3DB55000
`define PHASE_BASE_DEG 8'd90
`define PHASE_STEP_DEG 8'd18
`define START_AUTO_BIT 13
`define START_DET_BIT 12
`endif

// ### byte_lane_dll_props.sv
// Port checker for the byte lane DLL register bank.
// Assumes a bind onto the bank, one clock clk_sys and reset rstn.
`timescale 1ns/1ns
`default_nettype none
module byte_lane_dll_props (
    input wire logic clk_sys, rstn, avs_read, avs_write, avs_waitrequest,
    input wire logic [11:0] avs_address,
    input wire logic [31:0] avs_readdata,
    input wire logic [1:0] avs_response,
    input wire logic master_locked, analog_probe_out, analog_probe_oe,
    input wire logic [3:0] slave_phase_trim,
    input wire logic [7:0] slave_phase_deg,
    input wire logic slave_start, phase_det_enable
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    logic bad;
    assign bad = !(avs_address inside {12'h1CC, 12'h1D0, 12'h1D4});
    ack_delay_a: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
        else $error("late ack");
    ack_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("long ack");
    decode_err_a: assert property (!avs_waitrequest && (avs_read || avs_write) |->
        (avs_response == 2'h3) == bad) else $error("bad response");
    err_data_a: assert property (!avs_waitrequest && avs_read && bad |-> !avs_readdata)
        else $error("bad data");
    phase_deg_a: assert property (slave_phase_deg ==
        8'(90 + 18 * slave_phase_trim[3:2] - 18 * slave_phase_trim[1:0])) else $error("bad phase");
    probe_off_a: assert property (!analog_probe_oe |-> !analog_probe_out)
        else $error("probe on");
    start_lock_a: assert property (slave_start |-> $past(master_locked))
        else $error("no lock");
    start_det_a: assert property (slave_start |-> phase_det_enable)
        else $error("no det");
endmodule
`default_nettype wire
